/* core/hior_defs.vh */
// Behaviour
// - sixteen 4 KB segments of the 64KB I/O space, segments 1 to 15 each mapped to any bus
// - an access inside a bus's assigned range goes to that bus
// - segment 0 always goes to the compatibility bus
// - segment-to-bus map comes from a software programmed range register
// - an unclaimed forwarded access that is not posted times out and is terminated
// - with aliasing on, expansion ranges inside segment 0 (0400h-0FFFh) route as 0100h-03FFh of segment 0
// - aliasing affects routing only; original address goes to the bus
// - one aliasing enable bit turns expansion aliasing on or off
// - writes are posted by default, subject to the posting enable
// - writes to 0020h-0021h, 0060h-0064h, 0070h are deferred
// - writes to 0092h, 00A0h-00A1h, 00F0h deferred even when posting enabled
// - ordinary I/O reads and writes are claimed and forwarded as PCI I/O
// - port 0CF8h, and 0CFCh when enable bit 31 is set, are configuration accesses; both ports never posted
// - configuration space for the controller and each bridge bus
// - configuration space chosen by bus number plus device number
// - bus 0: controller 10h, 11h reserved, bridge buses 12h to 15h
// - bus 0 devices 0 to 15 go to the compatibility bus
// - bus 0 device 31, function all ones, register 0 write makes special cycle
// - compatibility bus is bridge 0 bus A, index 0
`ifndef HIOR_DEFS_VH
`define HIOR_DEFS_VH
`define HIOR_SEG_MSB 15
`define HIOR_SEG_LSB 12
`define HIOR_COMPAT_BUS 2'h0
`define HIOR_CFG_ADDR_PORT 16'h0CF8
`define HIOR_CFG_DATA_PORT 16'h0CFC
`define HIOR_ALIAS_LO 10'h100
`define HIOR_ALIAS_HI 10'h3FF
`define HIOR_PIC_M_LO 16'h0020
`define HIOR_PIC_M_HI 16'h0021
`define HIOR_KBC_LO 16'h0060
`define HIOR_KBC_HI 16'h0064
`define HIOR_NMI_PORT 16'h0070
`define HIOR_A20_PORT 16'h0092
`define HIOR_PIC_S_LO 16'h00A0
`define HIOR_PIC_S_HI 16'h00A1
`define HIOR_FERR_PORT 16'h00F0
`define HIOR_DEV_CTRL 5'h10
`define HIOR_DEV_RSVD 5'h11
`define HIOR_DEV_BR_LO 5'h12
`define HIOR_DEV_BR_HI 5'h15
`define HIOR_DEV_COMPAT_MAX 5'h0F
`define HIOR_DEV_SPECIAL 5'h1F
`define HIOR_TIMEOUT_NS 2560
`define HIOR_CLK_NS 10
`define HIOR_TIMEOUT_CYC (`HIOR_TIMEOUT_NS / `HIOR_CLK_NS)
`define HIOR_CFG_EN_BIT 31
`define HIOR_DST_CTRL 3'h4
`define HIOR_DST_NONE 3'h7
`endif

/* core/hior_router.v */
`timescale 1ns/1ps
`include "hior_defs.vh"
module hior_router #(
   parameter TIMEOUT_CYC = `HIOR_TIMEOUT_CYC
) (
   input wire CLK_SYS,
   input wire RST_N,
   // software controls
   input wire [63:0] IO_RANGE_MAP,
   input wire ALIAS_EN,
   input wire POST_EN,
   // host request
   input wire REQ_VALID,
   input wire REQ_WRITE,
   input wire [15:0] REQ_ADDR,
   input wire [31:0] REQ_WDATA,
   output wire REQ_READY,
   // host completion
   output reg RSP_VALID,
   output reg RSP_POSTED,
   output reg RSP_TIMEOUT,
   output reg [31:0] RSP_RDATA,
   // bridge side
   output reg PCI_VALID,
   output reg [1:0] PCI_BUS,
   output reg PCI_WRITE,
   output reg PCI_CONFIG,
   output reg PCI_SPECIAL,
   output reg [31:0] PCI_ADDR,
   output reg [31:0] PCI_WDATA,
   input wire PCI_CLAIM,
   input wire PCI_DONE,
   input wire [31:0] PCI_RDATA,
   // controller's own configuration space
   output reg CTRL_CFG_VALID,
   output reg CTRL_CFG_WRITE,
   output reg [7:0] CTRL_CFG_REG,
   output reg [31:0] CTRL_CFG_WDATA,
   input wire CTRL_CFG_DONE,
   input wire [31:0] CTRL_CFG_RDATA,
   output reg [31:0] CFG_ADDR_OUT
);
   localparam ST_IDLE = 3'b001;
   localparam ST_WAIT = 3'b010;
   localparam ST_CTRL = 3'b100;
   localparam TW = 16;

   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg [TW-1:0] tmo_reg;
   reg [31:0] cfg_addr_reg;

   // routing decode
   wire [9:0] low10 = REQ_ADDR[9:0];
   wire expand = (REQ_ADDR[`HIOR_SEG_MSB:`HIOR_SEG_LSB] == 4'h0) && (REQ_ADDR[15:10] != 6'h00)
      && (low10 >= `HIOR_ALIAS_LO) && (low10 <= `HIOR_ALIAS_HI);
   wire [15:0] route_addr = (ALIAS_EN && expand) ? {6'h00, low10} : REQ_ADDR;
   wire [3:0] seg = route_addr[`HIOR_SEG_MSB:`HIOR_SEG_LSB];
   // one bus entry per segment, segment 0 pinned
   wire [1:0] seg_tab [0:15];
   genvar gi;
   generate
      for (gi = 0; gi < 16; gi = gi + 1) begin : g_seg
         if (gi == 0) begin : g_compat
            assign seg_tab[gi] = `HIOR_COMPAT_BUS;
         end else begin : g_map
            assign seg_tab[gi] = IO_RANGE_MAP[gi*4 +: 2];
         end
      end
   endgenerate
   wire [1:0] seg_bus = seg_tab[seg];

   // configuration ports
   wire is_cfg_addr = (REQ_ADDR == `HIOR_CFG_ADDR_PORT);
   wire is_cfg_data = (REQ_ADDR == `HIOR_CFG_DATA_PORT) && cfg_addr_reg[`HIOR_CFG_EN_BIT];
   wire [7:0] cfg_bus = cfg_addr_reg[23:16];
   wire [4:0] cfg_dev = cfg_addr_reg[15:11];
   wire [2:0] cfg_fn = cfg_addr_reg[10:8];
   wire [7:0] cfg_regn = cfg_addr_reg[7:0];

   // configuration destination
   reg [2:0] cfg_dst;
   reg cfg_special;
   always @* begin
      cfg_dst = `HIOR_DST_NONE;
      cfg_special = 1'b0;
      if (cfg_bus != 8'h00) begin
         cfg_dst = 3'h0;
      end else if (cfg_dev <= `HIOR_DEV_COMPAT_MAX) begin
         cfg_dst = {1'b0, `HIOR_COMPAT_BUS};
      end else if (cfg_dev == `HIOR_DEV_CTRL) begin
         cfg_dst = `HIOR_DST_CTRL;
      end else if (cfg_dev >= `HIOR_DEV_BR_LO && cfg_dev <= `HIOR_DEV_BR_HI) begin
         cfg_dst = {1'b0, cfg_dev[1:0] - 2'h2};
      end else if (cfg_dev == `HIOR_DEV_SPECIAL && REQ_WRITE && cfg_fn == 3'h7 && cfg_regn == 8'h00) begin
         cfg_dst = {1'b0, `HIOR_COMPAT_BUS};
         cfg_special = 1'b1;
      end
   end

   // posting decision
   // restricted ports, one address range per entry
   localparam NRNG = 6;
   wire [16*NRNG-1:0] rng_lo = {`HIOR_FERR_PORT, `HIOR_PIC_S_LO, `HIOR_A20_PORT, `HIOR_NMI_PORT, `HIOR_KBC_LO,
      `HIOR_PIC_M_LO};
   wire [16*NRNG-1:0] rng_hi = {`HIOR_FERR_PORT, `HIOR_PIC_S_HI, `HIOR_A20_PORT, `HIOR_NMI_PORT, `HIOR_KBC_HI,
      `HIOR_PIC_M_HI};
   wire [NRNG-1:0] rng_hit;
   generate
      for (gi = 0; gi < NRNG; gi = gi + 1) begin : g_rng
         assign rng_hit[gi] = (REQ_ADDR >= rng_lo[gi*16 +: 16]) && (REQ_ADDR <= rng_hi[gi*16 +: 16]);
      end
   endgenerate
   wire no_post_legacy = |rng_hit[2:0];
   wire no_post_more = |rng_hit[5:3];
   wire no_post = no_post_legacy || no_post_more || is_cfg_addr || (REQ_ADDR == `HIOR_CFG_DATA_PORT);
   wire post_ok = REQ_WRITE && POST_EN && !no_post;

   assign REQ_READY = (state_reg == ST_IDLE);
   wire take = REQ_VALID && REQ_READY;

   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (take && !is_cfg_addr) begin
               if (is_cfg_data && cfg_dst == `HIOR_DST_CTRL) begin
                  state_next = ST_CTRL;
               end else if (!(is_cfg_data && cfg_dst == `HIOR_DST_NONE) && !post_ok) begin
                  state_next = ST_WAIT;
               end
            end
         end
         ST_WAIT: begin
            if (PCI_DONE || tmo_reg == TIMEOUT_CYC[TW-1:0] - 16'h0001) begin
               state_next = ST_IDLE;
            end
         end
         ST_CTRL: begin
            if (CTRL_CFG_DONE) begin
               state_next = ST_IDLE;
            end
         end
         default: state_next = ST_IDLE;
      endcase
   end

   always @(posedge CLK_SYS) begin
      if (!RST_N) begin
         state_reg <= ST_IDLE;
         tmo_reg <= 16'h0000;
         cfg_addr_reg <= 32'h00000000;
         RSP_VALID <= 1'b0;
         RSP_POSTED <= 1'b0;
         RSP_TIMEOUT <= 1'b0;
         RSP_RDATA <= 32'h00000000;
         PCI_VALID <= 1'b0;
         PCI_BUS <= 2'h0;
         PCI_WRITE <= 1'b0;
         PCI_CONFIG <= 1'b0;
         PCI_SPECIAL <= 1'b0;
         PCI_ADDR <= 32'h00000000;
         PCI_WDATA <= 32'h00000000;
         CTRL_CFG_VALID <= 1'b0;
         CTRL_CFG_WRITE <= 1'b0;
         CTRL_CFG_REG <= 8'h00;
         CTRL_CFG_WDATA <= 32'h00000000;
         CFG_ADDR_OUT <= 32'h00000000;
      end else begin
         state_reg <= state_next;
         RSP_VALID <= 1'b0;
         RSP_POSTED <= 1'b0;
         RSP_TIMEOUT <= 1'b0;
         PCI_VALID <= 1'b0;
         CTRL_CFG_VALID <= 1'b0;
         CFG_ADDR_OUT <= cfg_addr_reg;
         case (state_reg)
            ST_IDLE: begin
               tmo_reg <= 16'h0000;
               if (take) begin
                  PCI_WRITE <= REQ_WRITE;
                  PCI_WDATA <= REQ_WDATA;
                  PCI_SPECIAL <= 1'b0;
                  if (is_cfg_addr) begin
                     if (REQ_WRITE) begin
                        cfg_addr_reg <= REQ_WDATA;
                     end
                     RSP_VALID <= 1'b1;
                     RSP_RDATA <= cfg_addr_reg;
                  end else if (is_cfg_data) begin
                     if (cfg_dst == `HIOR_DST_CTRL) begin
                        CTRL_CFG_VALID <= 1'b1;
                        CTRL_CFG_WRITE <= REQ_WRITE;
                        CTRL_CFG_REG <= cfg_regn;
                        CTRL_CFG_WDATA <= REQ_WDATA;
                     end else if (cfg_dst == `HIOR_DST_NONE) begin
                        RSP_VALID <= 1'b1;
                        RSP_RDATA <= 32'hFFFFFFFF;
                     end else begin
                        PCI_VALID <= 1'b1;
                        PCI_BUS <= cfg_dst[1:0];
                        PCI_CONFIG <= 1'b1;
                        PCI_SPECIAL <= cfg_special;
                        PCI_ADDR <= cfg_addr_reg;
                     end
                  end else begin
                     PCI_VALID <= 1'b1;
                     PCI_BUS <= seg_bus;
                     PCI_CONFIG <= 1'b0;
                     PCI_ADDR <= {16'h0000, REQ_ADDR};
                     if (post_ok) begin
                        RSP_VALID <= 1'b1;
                        RSP_POSTED <= 1'b1;
                     end
                  end
               end
            end
            ST_WAIT: begin
               if (!PCI_CLAIM) begin
                  tmo_reg <= tmo_reg + 16'h0001;
               end
               if (PCI_DONE) begin
                  RSP_VALID <= 1'b1;
                  RSP_RDATA <= PCI_RDATA;
               end else if (tmo_reg == TIMEOUT_CYC[TW-1:0] - 16'h0001) begin
                  RSP_VALID <= 1'b1;
                  RSP_TIMEOUT <= 1'b1;
                  RSP_RDATA <= 32'hFFFFFFFF;
               end
            end
            ST_CTRL: begin
               if (CTRL_CFG_DONE) begin
                  RSP_VALID <= 1'b1;
                  RSP_RDATA <= CTRL_CFG_RDATA;
               end
            end
            default: begin
               tmo_reg <= 16'h0000;
            end
         endcase
      end
   end
endmodule // hior_router

/* dv/hior_monitor.sv */
`timescale 1ns/1ps
module hior_monitor #(
   parameter TIMEOUT_CYC = 8
) (
   input wire CLK_SYS,
   input wire RST_N,
   input wire [63:0] IO_RANGE_MAP,
   input wire POST_EN,
   input wire REQ_VALID,
   input wire REQ_WRITE,
   input wire [15:0] REQ_ADDR,
   input wire REQ_READY,
   input wire RSP_VALID,
   input wire RSP_POSTED,
   input wire RSP_TIMEOUT,
   input wire PCI_VALID,
   input wire [1:0] PCI_BUS,
   input wire PCI_WRITE,
   input wire PCI_CONFIG,
   input wire PCI_SPECIAL,
   input wire [31:0] PCI_ADDR,
   input wire PCI_CLAIM,
   input wire CTRL_CFG_VALID,
   input wire [31:0] CFG_ADDR_OUT
);
   wire tk = REQ_VALID && REQ_READY;
   wire cfgp = REQ_ADDR == 16'h0CF8 || REQ_ADDR == 16'h0CFC;
   wire np = (REQ_ADDR >= 16'h0020 && REQ_ADDR <= 16'h0021) || (REQ_ADDR >= 16'h0060 && REQ_ADDR <= 16'h0064)
      || REQ_ADDR == 16'h0070 || REQ_ADDR == 16'h0092 || REQ_ADDR == 16'h00A0 || REQ_ADDR == 16'h00A1
      || REQ_ADDR == 16'h00F0;
   wire [1:0] xb = REQ_ADDR[15:12] == 4'h0 ? 2'h0 : IO_RANGE_MAP[{REQ_ADDR[15:12], 2'h0} +: 2];
   reg [15:0] w_reg;
   // unclaimed wait cycles
   always @(posedge CLK_SYS) begin
      if (!RST_N || PCI_VALID || RSP_VALID) w_reg <= 16'h0;
      else if (!REQ_READY && !PCI_CLAIM) w_reg <= w_reg + 16'h1;
   end
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);
   post_write_a: assert property (tk && REQ_WRITE && POST_EN && !np && !cfgp |=> RSP_VALID && RSP_POSTED)
      else $error("plain write not posted");
   defer_ports_a: assert property (tk && REQ_WRITE && np |=> !RSP_POSTED)
      else $error("restricted port write posted");
   cfg_nopost_a: assert property (tk && REQ_WRITE && cfgp |=> !RSP_POSTED)
      else $error("config port write posted");
   seg_route_a: assert property (tk && !cfgp |=> PCI_VALID && PCI_BUS == $past(xb))
      else $error("wrong target bus");
   orig_addr_a: assert property (tk && !cfgp |=> PCI_ADDR == {16'h0, $past(REQ_ADDR)}
      && PCI_WRITE == $past(REQ_WRITE) && !PCI_CONFIG)
      else $error("forwarded address or kind altered");
   tmo_late_a: assert property (w_reg <= TIMEOUT_CYC + 2)
      else $error("unclaimed access not terminated");
   tmo_early_a: assert property (RSP_TIMEOUT |-> RSP_VALID && w_reg >= TIMEOUT_CYC - 1)
      else $error("early timeout");
   special_cyc_a: assert property (PCI_VALID && PCI_SPECIAL |-> PCI_CONFIG && PCI_WRITE && PCI_ADDR[23:0] == 24'h00FF00)
      else $error("bad special cycle");
   ctrl_dev_a: assert property (CTRL_CFG_VALID |-> CFG_ADDR_OUT[23:11] == 13'h0010)
      else $error("controller answered wrong device");
   cover property (RSP_VALID && RSP_POSTED);
   cover property (RSP_TIMEOUT);
   cover property (PCI_VALID && PCI_SPECIAL);
endmodule // hior_monitor
bind hior_router hior_monitor #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_mon (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
   .IO_RANGE_MAP(IO_RANGE_MAP), .POST_EN(POST_EN), .REQ_VALID(REQ_VALID), .REQ_WRITE(REQ_WRITE),
   .REQ_ADDR(REQ_ADDR), .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID), .RSP_POSTED(RSP_POSTED),
   .RSP_TIMEOUT(RSP_TIMEOUT), .PCI_VALID(PCI_VALID), .PCI_BUS(PCI_BUS), .PCI_WRITE(PCI_WRITE),
   .PCI_CONFIG(PCI_CONFIG), .PCI_SPECIAL(PCI_SPECIAL), .PCI_ADDR(PCI_ADDR), .PCI_CLAIM(PCI_CLAIM),
   .CTRL_CFG_VALID(CTRL_CFG_VALID), .CFG_ADDR_OUT(CFG_ADDR_OUT));

/* dv/hior_bridge_model.sv */
`timescale 1ns/1ps
module hior_bridge_model (
   input wire clk,
   input wire rst_n,
   input wire [1:0] mode,
   input wire valid,
   input wire [31:0] addr,
   input wire ctrl_valid,
   output reg claim,
   output reg done,
   output reg [31:0] rdata,
   output reg ctrl_done,
   output reg [31:0] ctrl_rdata
);
   integer cnt;
   reg [15:0] a_reg;
   // mode 0 prompt, 1 slow, 2 nobody claims
   always @(posedge clk) begin
      done <= 1'b0;
      rdata <= ~rdata;
      ctrl_done <= ctrl_valid;
      ctrl_rdata <= ctrl_valid ? 32'h0C0F0010 : ~ctrl_rdata;
      if (!rst_n) begin
         cnt <= 0;
         claim <= 1'b0;
         rdata <= 32'h0;
         ctrl_rdata <= 32'h0;
      end else if (valid && mode != 2'h2) begin
         cnt <= mode == 2'h1 ? 6 : 1;
         claim <= 1'b1;
         a_reg <= addr[15:0];
      end else if (cnt == 1) begin
         cnt <= 0;
         claim <= 1'b0;
         done <= 1'b1;
         rdata <= {16'hA5A5, a_reg};
      end else if (cnt > 1) cnt <= cnt - 1;
   end
endmodule // hior_bridge_model

/* dv/hior_router_tb.sv */
`timescale 1ns/1ps
module hior_router_tb;
   reg CLK_SYS = 0, RST_N = 0, alias_en = 0, post_en = 0, rv = 0, rw = 0, w, ssp, spc, scw;
   reg [7:0] scr;
   reg [63:0] map = 0;
   reg [15:0] ra = 0, a;
   reg [31:0] rd = 0, sa, sd, scd;
   reg [1:0] mode = 0, sb;
   reg [15:0] dp [0:11] = '{16'h0020, 16'h0021, 16'h0060, 16'h0061, 16'h0062, 16'h0063, 16'h0064, 16'h0070,
      16'h0092, 16'h00A0, 16'h00A1, 16'h00F0};
   wire rdy, rsp_v, rsp_p, rsp_t, pv, pw, pc, ps, claim, done, cv, cdone, cw;
   wire [31:0] rsp_d, pa, prd, crd, pwd, cwd;
   wire [7:0] creg;
   wire [1:0] pbus;
   integer seed = 32'h3d0fc095, bad_count = 0, samples_checked = 0, cyc = 0, i, n;
   always #5 CLK_SYS = ~CLK_SYS;
   hior_router #(.TIMEOUT_CYC(8)) u_dut (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .IO_RANGE_MAP(map),
      .ALIAS_EN(alias_en), .POST_EN(post_en), .REQ_VALID(rv), .REQ_WRITE(rw), .REQ_ADDR(ra), .REQ_WDATA(rd),
      .REQ_READY(rdy), .RSP_VALID(rsp_v), .RSP_POSTED(rsp_p), .RSP_TIMEOUT(rsp_t), .RSP_RDATA(rsp_d),
      .PCI_VALID(pv), .PCI_BUS(pbus), .PCI_WRITE(pw), .PCI_CONFIG(pc), .PCI_SPECIAL(ps), .PCI_ADDR(pa),
      .PCI_WDATA(pwd), .PCI_CLAIM(claim), .PCI_DONE(done), .PCI_RDATA(prd), .CTRL_CFG_VALID(cv),
      .CTRL_CFG_WRITE(cw), .CTRL_CFG_REG(creg), .CTRL_CFG_WDATA(cwd), .CTRL_CFG_DONE(cdone),
      .CTRL_CFG_RDATA(crd),
      .CFG_ADDR_OUT());
   hior_bridge_model u_far (.clk(CLK_SYS), .rst_n(RST_N), .mode(mode), .valid(pv), .addr(pa),
      .ctrl_valid(cv), .claim(claim), .done(done), .rdata(prd), .ctrl_done(cdone), .ctrl_rdata(crd));
   task chk(input [31:0] got, input [31:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   function np(input [15:0] x);
      np = (x >= 16'h0020 && x <= 16'h0021) || (x >= 16'h0060 && x <= 16'h0064) || x == 16'h0070
         || x == 16'h0092 || x == 16'h00A0 || x == 16'h00A1 || x == 16'h00F0;
   endfunction
   // one transfer, then waits for completion
   task acc(input [1:0] m, input wr, input [15:0] ad, input [31:0] d);
      begin
         @(posedge CLK_SYS);
         mode <= m;
         rv <= 1'b1;
         rw <= wr;
         ra <= ad;
         rd <= d;
         do @(negedge CLK_SYS); while (rdy !== 1'b1);
         @(posedge CLK_SYS);
         rv <= 1'b0;
         n = 0;
         sb = 2'bxx;
         sa = 32'hx;
         ssp = 1'bx;
         spc = 1'bx;
         sd = 32'hx;
         scw = 1'bx;
         scr = 8'hxx;
         scd = 32'hx;
         // sample only at falling edges, where outputs have settled
         do begin
            @(negedge CLK_SYS);
            n = n + 1;
            if (pv === 1'b1) begin
               sb = pbus;
               sa = pa;
               ssp = ps;
               spc = pc;
               sd = pwd;
            end
            if (cv === 1'b1) begin
               scw = cw;
               scr = creg;
               scd = cwd;
            end
         end while (rsp_v !== 1'b1 && n < 40);
         chk(n < 40, 1);
      end
   endtask
   task results;
      begin
         $display("checked=%0d mismatches=%0d", samples_checked, bad_count);
         if (bad_count == 0 && samples_checked > 0) $display("Test passed");
         else $display("Test failed");
         $finish;
      end
   endtask
   always @(posedge CLK_SYS) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         bad_count = bad_count + 1;
         results;
      end
   end
   initial begin
      repeat (12) @(posedge CLK_SYS);
      RST_N <= 1'b1;
      for (i = 0; i < 60; i = i + 1) begin
         @(posedge CLK_SYS);
         map <= {$random(seed), $random(seed)};
         post_en <= $random(seed);
         alias_en <= $random(seed);
         a = $random(seed);
         w = $random(seed);
         if (i % 4 == 0) a[15:12] = 4'h0;
         if (a == 16'h0CF8 || a == 16'h0CFC) a = 16'h0CF0;
         acc(0, w, a, $random(seed));
         chk(sb, a[15:12] == 4'h0 ? 2'h0 : map[a[15:12] * 4 +: 2]);
         chk(sa, {16'h0, a});
         chk(spc, 0);
         if (w) chk(sd, rd);
         chk(rsp_p, w && post_en && !np(a));
         if (!w) chk(rsp_d, {16'hA5A5, a});
      end
      @(posedge CLK_SYS);
      post_en <= 1'b1;
      for (i = 0; i < 12; i = i + 1) begin
         acc(0, 1, dp[i], 0);
         chk(rsp_p, 0);
      end
      acc(2, 0, 16'h3000, 0);
      chk(rsp_t, 1);
      chk(rsp_d, 32'hFFFFFFFF);
      acc(1, 0, 16'h3004, 0);
      chk(rsp_d, 32'hA5A53004);
      chk(rsp_t, 0);
      acc(0, 1, 16'h0CF8, 32'h80008000);
      chk(rsp_p, 0);
      acc(0, 0, 16'h0CFC, 0);
      chk(rsp_d, 32'h0C0F0010);
      acc(0, 1, 16'h0CF8, 32'h80001800);
      acc(0, 0, 16'h0CFC, 0);
      chk(sb, 0);
      acc(0, 1, 16'h0CF8, 32'h8000FF00);
      acc(0, 1, 16'h0CFC, 0);
      chk(ssp, 1);
      chk(rsp_p, 0);
      acc(0, 1, 16'h0CF8, 32'h8000803C);
      acc(0, 1, 16'h0CFC, 32'h5A5AC3C3);
      chk(scw, 1);
      chk(scr, 8'h3C);
      chk(scd, 32'h5A5AC3C3);
      acc(0, 0, 16'h0CF8, 0);
      chk(rsp_d, 32'h8000803C);
      // bridge buses answer as devices 12h to 15h
      for (i = 0; i < 4; i = i + 1) begin
         acc(0, 1, 16'h0CF8, 32'h80009000 + i * 32'h00000800);
         acc(0, 0, 16'h0CFC, 0);
         chk(sb, i);
         chk(spc, 1);
      end
      acc(0, 1, 16'h0CF8, 32'h80008800);
      acc(0, 0, 16'h0CFC, 0);
      chk(rsp_d, 32'hFFFFFFFF);
      acc(0, 1, 16'h0CF8, 32'h80051000);
      acc(0, 0, 16'h0CFC, 0);
      chk(sb, 0);
      chk(sa, 32'h80051000);
      // enable bit clear: data port is plain I/O
      acc(0, 1, 16'h0CF8, 32'h00008000);
      acc(0, 0, 16'h0CFC, 0);
      chk(spc, 0);
      chk(rsp_d, 32'hA5A50CFC);
      results;
   end
endmodule // hior_router_tb
